// >>> common/acds_map.svh
// Purpose: register offsets, field positions and reset values for the
//          clock detect status block
// Assumes: byte addresses are four times the printed register index
// Notes:   included by the status block and its rate classifier
// Function
// - secondary port rate code sits in bits 7..2 at index 0x3F, reset zero
// - codes 1..10 mean 768000 down to 192000 Hz, each with a window
// - codes 11..20 mean 170667 down to 48000 Hz, 20 is 41895..49440
// - codes 21..30 mean 42667 down to 12000 Hz, 28 is 13905..16480
// - codes 31..40 mean 10667 down to 3000 Hz; 0, 41..63 reserved
// - reserved bits 1..0 and ratio high bits 7..6 read zero
// - ratio upper six bits in bits 5..0 at index 0x40, reset zero
// - third ratio register at index 0x41 resets to 0x00
// - ratio lower eight bits fill the third register, 14 bits total
`ifndef ACDS_MAP_SVH
`define ACDS_MAP_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define ACDS_IDX_RATE      8'h3F
`define ACDS_IDX_RATIO_HI  8'h40
`define ACDS_IDX_RATIO_LO  8'h41
`define ACDS_ADDR_W        10
`define ACDS_RESET_BYTE    8'h00
`define ACDS_RATE_LSB      2
`define ACDS_CODE_NONE     6'h00
`define ACDS_CODE_LAST     6'h28

`endif

// >>> common/acds_pkg.sv
// Purpose: shared types for the clock detect status block
// Assumes: nothing beyond the map header
// Notes:   bus state, rate code and ratio types; offsets live in the header
package acds_pkg;
  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {ACDS_IDLE, ACDS_ACK} acds_bus_state_t;
  typedef logic [5:0] acds_code_t;
  typedef logic [13:0] acds_ratio_t;
endpackage

// >>> rtl/acds_rate_table.sv
// Purpose: classify a measured frame rate in Hz into a 6-bit rate code
// Assumes: rate is stable in the cycle it is sampled
// Notes:   registered output, one cycle latency; gaps give code 0
`timescale 1ns/100ps
`include "acds_map.svh"
module acds_rate_table
  import acds_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [19:0] rate_hz,
  output acds_code_t       code
);
  // lower and upper window edges, entry k is code k+1
  localparam logic [19:0] LO [40] = '{
    20'd670320, 20'd536256, 20'd446880, 20'd383040, 20'd335160,
    20'd297920, 20'd268128, 20'd223440, 20'd191520, 20'd167580,
    20'd148960, 20'd134064, 20'd111720, 20'd95760,  20'd83790,
    20'd74480,  20'd67032,  20'd55860,  20'd47880,  20'd41895,
    20'd37240,  20'd33516,  20'd27930,  20'd23940,  20'd20947,
    20'd18620,  20'd16758,  20'd13905,  20'd11970,  20'd10473,
    20'd9310,   20'd8379,   20'd6982,   20'd5985,   20'd5236,
    20'd4655,   20'd4189,   20'd3491,   20'd2992,   20'd2618};
  localparam logic [19:0] HI [40] = '{
    20'd791040, 20'd632832, 20'd527360, 20'd452022, 20'd395520,
    20'd351573, 20'd316416, 20'd263680, 20'd226011, 20'd197760,
    20'd175786, 20'd158208, 20'd131840, 20'd113005, 20'd98880,
    20'd87893,  20'd79104,  20'd65920,  20'd56502,  20'd49440,
    20'd43946,  20'd39552,  20'd32960,  20'd28251,  20'd24720,
    20'd21973,  20'd19776,  20'd16480,  20'd14125,  20'd12360,
    20'd10986,  20'd9888,   20'd8240,   20'd7062,   20'd6180,
    20'd5493,   20'd4944,   20'd4120,   20'd3531,   20'd3090};

  // codes whose nominal rate is fractional; they lose every overlap
  localparam logic [39:0] FRAC = 40'h4A_5294_A528;

  logic [39:0] hit;
  acds_code_t  next_code;

  // one window compare per code
  genvar g;
  generate
    for (g = 0; g < 40; g++)
    begin : g_win
      assign hit[g] = (rate_hz >= LO[g]) && (rate_hz <= HI[g]);
    end
  endgenerate

  // windows overlap only where a fractional rate meets a round one; the
  // round rate wins, so 48 kHz or 12 kHz never read as an odd neighbour
  always_comb
  begin
    next_code = `ACDS_CODE_NONE;
    for (int k = 39; k >= 0; k--)
    begin
      if (hit[k])
        next_code = 6'(k + 1);
    end
    for (int k = 39; k >= 0; k--)
    begin
      if (hit[k] && !FRAC[k])
        next_code = 6'(k + 1);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      code <= `ACDS_CODE_NONE;
    else
      code <= next_code;
  end
endmodule

// >>> rtl/acds_status.sv
// Purpose: read-only clock detect status registers on classic Wishbone
// Assumes: measurement engine gives rate and ratio with a done pulse
// Notes:   writes are acknowledged and ignored; unmapped reads return 0
//
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps
`include "acds_map.svh"
module acds_status
  import acds_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [`ACDS_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    meas_done,
  input  wire logic                    meas_valid,
  input  wire logic [19:0]             meas_rate_hz,
  input  wire logic [13:0]             meas_ratio
);
  // ----------------------------------------------------------------------
  // measurement capture
  // ----------------------------------------------------------------------
  acds_code_t  table_code;
  acds_code_t  rate_code;
  acds_code_t  next_rate_code;
  acds_ratio_t ratio;
  acds_ratio_t next_ratio;
  logic        done_d;
  logic        valid_d;
  acds_ratio_t ratio_d;

  acds_rate_table u_table (
    .clk     (clk),
    .resetn  (resetn),
    .rate_hz (meas_rate_hz),
    .code    (table_code)
  );

  // ratio is delayed one cycle so both land with the table output
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      done_d  <= 1'b0;
      valid_d <= 1'b0;
      ratio_d <= '0;
    end
    else
    begin
      done_d  <= meas_done;
      valid_d <= meas_valid;
      ratio_d <= meas_ratio;
    end
  end

  // both fields change in one edge so a read never sees a mix
  always_comb
  begin
    next_rate_code = rate_code;
    next_ratio     = ratio;
    if (done_d)
    begin
      next_rate_code = valid_d ? table_code : `ACDS_CODE_NONE;
      next_ratio     = ratio_d;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rate_code <= `ACDS_CODE_NONE;
      ratio     <= '0;
    end
    else
    begin
      rate_code <= next_rate_code;
      ratio     <= next_ratio;
    end
  end

  // ----------------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------------
  logic [7:0]  idx;
  logic [7:0]  rd_byte;
  logic [31:0] next_dat;
  logic        next_ack;

  assign idx = wb_adr_i[`ACDS_ADDR_W-1:2];

  // register read mux; reserved bits read zero
  always_comb
  begin
    case (idx)
      `ACDS_IDX_RATE:     rd_byte = {rate_code, 2'b00};
      `ACDS_IDX_RATIO_HI: rd_byte = {2'b00, ratio[13:8]};
      `ACDS_IDX_RATIO_LO: rd_byte = ratio[7:0];
      default:            rd_byte = `ACDS_RESET_BYTE;
    endcase
  end

  // one wait state, ack drops the cycle after it rose
  always_comb
  begin
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat = wb_dat_o;
    if (next_ack)
      next_dat = wb_we_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_done_valid;
    done_d && valid_d;
  endsequence

  property p_code_follows;
    @(posedge clk) disable iff (!resetn)
      s_done_valid |=> rate_code == $past(table_code);
  endproperty
  a_code_follows: assert property (p_code_follows)
    else $error("rate code not loaded from table");

  property p_invalid_zero;
    @(posedge clk) disable iff (!resetn)
      done_d && !valid_d |=> rate_code == 6'h00;
  endproperty
  a_invalid_zero: assert property (p_invalid_zero)
    else $error("rate code not zero after invalid measurement");

  property p_code_range;
    @(posedge clk) disable iff (!resetn)
      rate_code <= `ACDS_CODE_LAST;
  endproperty
  a_code_range: assert property (p_code_range)
    else $error("reserved rate code reported");

  property p_hold;
    @(posedge clk) disable iff (!resetn)
      !done_d |=> $stable(rate_code) && $stable(ratio);
  endproperty
  a_hold: assert property (p_hold)
    else $error("status changed without a measurement");

  property p_48k;
    @(posedge clk) disable iff (!resetn)
      meas_rate_hz == 20'd48000 ##1 1'b1 |-> table_code == 6'd20;
  endproperty
  a_48k: assert property (p_48k)
    else $error("48 kHz not classed as code 20");

  property p_rd_rate;
    @(posedge clk) disable iff (!resetn)
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
        && idx == `ACDS_IDX_RATE
      |=> wb_ack_o && wb_dat_o == {24'h0, $past(rate_code), 2'b00};
  endproperty
  a_rd_rate: assert property (p_rd_rate)
    else $error("rate register read wrong");

  property p_rd_hi;
    @(posedge clk) disable iff (!resetn)
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
        && idx == `ACDS_IDX_RATIO_HI
      |=> wb_dat_o == {26'h0, $past(ratio[13:8])};
  endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("ratio high read wrong");

  property p_rd_lo;
    @(posedge clk) disable iff (!resetn)
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
        && idx == `ACDS_IDX_RATIO_LO
      |=> wb_dat_o == {24'h0, $past(ratio[7:0])};
  endproperty
  a_rd_lo: assert property (p_rd_lo)
    else $error("ratio low read wrong");

  property p_ratio_load;
    @(posedge clk) disable iff (!resetn)
      done_d |=> ratio == $past(ratio_d);
  endproperty
  a_ratio_load: assert property (p_ratio_load)
    else $error("ratio not loaded with rate code");

  property p_ack_pulse;
    @(posedge clk) disable iff (!resetn)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");
endmodule

// >>> verif/acds_status_bench.sv
// Purpose: self-checking bench for the clock detect status block
// Assumes: status changes within three cycles of a done pulse
// Notes:   driver queues expected data, monitor checks it at ack
`timescale 1ns/100ps
`include "acds_map.svh"
module acds_status_bench;
  logic                    clk, resetn, cyc, stb, we, done, valid;
  logic                    wb_ack_o;
  logic [`ACDS_ADDR_W-1:0] adr;
  logic [3:0]              sel;
  logic [31:0]             wdat, wb_dat_o, exp_q[$];
  logic [31:0]             seed = 32'h0000_76cb;
  logic [19:0]             rate;
  logic [13:0]             ratio, held;
  int                      miscompares = 0;
  int                      n_checks = 0;
  // windows probed at edges and overlaps; round rates win an overlap
  int unsigned             rates[16] = '{670320, 791040, 768000, 180000,
    41895, 48000, 13905, 16480, 10473, 12000, 2618, 2800, 2617, 670319,
    791041, 3000};
  logic [5:0]              codes[16] = '{1, 1, 1, 10, 20, 20, 28, 28, 30,
    30, 40, 40, 0, 0, 0, 0};

  acds_status u_acds_status (
    .clk          (clk),
    .resetn       (resetn),
    .wb_cyc_i     (cyc),
    .wb_stb_i     (stb),
    .wb_we_i      (we),
    .wb_adr_i     (adr),
    .wb_sel_i     (sel),
    .wb_dat_i     (wdat),
    .wb_dat_o     (wb_dat_o),
    .wb_ack_o     (wb_ack_o),
    .meas_done    (done),
    .meas_valid   (valid),
    .meas_rate_hz (rate),
    .meas_ratio   (ratio)
  );

  // ----------------------------------------------------------------------
  // clock, helpers
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic fail(input string m);
    miscompares++;
    $display("MISMATCH %0t %s", $time, m);
  endtask

  task automatic summarize();
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic access(input logic w, input logic [9:0] a,
                        input logic [31:0] e);
    int n = 0;
    @(posedge clk);
    seed = xs(seed);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= w ? 32'h0000_0000 : seed;
    sel  <= seed[7:4];
    exp_q.push_back(e);
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (wb_ack_o !== 1'b1)
      fail("no ack");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // done pulse; inputs turn to their inverse once it is over
  task automatic measure(input logic v, input logic [19:0] r);
    @(posedge clk);
    seed = xs(seed);
    held = seed[13:0];
    done  <= 1'b1;
    valid <= v;
    rate  <= r;
    ratio <= seed[13:0];
    @(posedge clk);
    done  <= 1'b0;
    valid <= ~v;
    rate  <= ~r;
    ratio <= ~seed[13:0];
    repeat (3) @(posedge clk);
  endtask

  task automatic check_all(input logic [5:0] c, input logic [13:0] q);
    access(1'b0, 10'h0FC, {24'h00_0000, c, 2'b00});
    access(1'b0, 10'h100, {26'h000_0000, q[13:8]});
    access(1'b0, 10'h104, {24'h00_0000, q[7:0]});
  endtask

  // ----------------------------------------------------------------------
  // monitor: oldest note is matched against the data seen with ack
  // ----------------------------------------------------------------------
  always @(posedge clk)
    if (wb_ack_o === 1'b1)
    begin
      n_checks++;
      if (exp_q.size() == 0 || wb_dat_o !== exp_q.pop_front())
        fail("read data differs");
    end

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    {cyc, stb, we, done, valid} = 5'h00;
    adr   = '0;
    sel   = 4'h0;
    wdat  = 32'h0000_0000;
    rate  = 20'h0_0000;
    ratio = 14'h0000;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    check_all(6'h00, 14'h0000);
    for (int i = 0; i < 16; i++)
    begin
      measure(i != 15, rates[i][19:0]);
      check_all(codes[i], held);
    end
    // a valid code before the writes, so the mid-run reset has work to do
    measure(1'b1, 20'd48000);
    // writes are answered but must leave the status alone
    access(1'b1, 10'h0FC, 32'h0000_0000);
    access(1'b1, 10'h100, 32'h0000_0000);
    check_all(6'd20, held);
    access(1'b0, 10'h108, 32'h0000_0000);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    check_all(6'h00, 14'h0000);
    summarize();
  end

  // the whole run needs roughly 290 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fail("timeout");
    summarize();
  end
endmodule
